// ==== hw/rtctod_pkg.sv ====
// Constants for the time-of-day counter registers
package rtctod_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [4:0] ADDR_HUNDREDTHS = 5'h00;
  localparam logic [4:0] ADDR_SECONDS    = 5'h01;
  localparam logic [4:0] ADDR_MINUTES    = 5'h02;
  localparam logic [4:0] ADDR_HOURS      = 5'h03;
  localparam logic [4:0] ADDR_LAST       = 5'h1F;
  localparam int         NUM_TOD_REGS    = 4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RUN_BIT      = 7;
  localparam int TRIM_BIT     = 7;
  localparam int FMT12_BIT    = 6;
  localparam int PM_BIT       = 5;
  localparam int TENS_HI      = 7;
  localparam int TENS_LO      = 4;
  localparam int ONES_HI      = 3;
  localparam int ONES_LO      = 0;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam logic [7:0] MINUTES_MASK    = 8'h7F;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------
  // BCD limits
  // ----------------------------------------
  localparam logic [3:0] DIGIT_MAX       = 4'h9;
  localparam logic [3:0] DIGIT_ZERO      = 4'h0;
  localparam logic [7:0] HUNDREDTHS_LAST = 8'h99;
  localparam logic [6:0] SIXTY_LAST      = 7'h59;
  localparam logic [5:0] HOURS24_LAST    = 6'h23;
  localparam logic [4:0] HOURS12_NOON    = 5'h12;
  localparam logic [4:0] HOURS12_ELEVEN  = 5'h11;
  localparam logic [4:0] HOURS12_FIRST   = 5'h01;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_HZ         = 125_000_000;
  localparam int TICK_HZ         = 4_096;
  localparam int TICK_DIV        = MCLK_HZ / TICK_HZ;
  localparam logic [5:0] HSEC_LONG  = 6'h29;
  localparam logic [5:0] HSEC_SHORT = 6'h28;
  localparam logic [4:0] HSEC_LONG_RUNS = 5'h18;

endpackage

// ==== hw/rtctod_top.sv ====
// Time-of-day counters with byte register port and read snapshot
`timescale 1ns/1ps

// Operation
// - Hundredths tens digit BCD in bits 7-4
// - Hundredths ones digit BCD in bits 3-0
// - Seconds bit 7 starts and stops counting
// - Seconds tens BCD 0-5 in bits 6-4
// - Seconds ones BCD 0-9 in bits 3-0
// - Unimplemented bits read zero, ignore writes
// - Minutes tens BCD 0-5 in bits 6-4
// - 24-hour tens BCD 0-2 in bits 5-4
// - Hours ones BCD 0-9 in bits 3-0
// - Hours bit 6 selects 12/24 rollover
// - All counters count in BCD form
// - Snapshot on read start and address wrap
module rtctod_top
  import rtctod_pkg::*;
#(
  parameter int TICK_DIV_P = TICK_DIV
)
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       read_start,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            osc_running,
  output logic            trim_direction,
  output logic            day_carry
);

  // ----------------------------------------
  // BCD helpers
  // ----------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] value);
    logic [7:0] result;
    result = value;
    if (value[ONES_HI:ONES_LO] == DIGIT_MAX)
    begin
      result[ONES_HI:ONES_LO] = DIGIT_ZERO;
      result[TENS_HI:TENS_LO] = value[TENS_HI:TENS_LO] + 4'h1;
    end
    else
    begin
      result[ONES_HI:ONES_LO] = value[ONES_HI:ONES_LO] + 4'h1;
    end
    return result;
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0]  hundredths_count_reg;
  logic [7:0]  seconds_count_and_run_reg;
  logic [7:0]  minutes_count_reg;
  logic [7:0]  hours_count_and_format_reg;
  logic [7:0]  snapshot_reg [NUM_TOD_REGS];
  logic [7:0]  live_value [NUM_TOD_REGS];
  logic [4:0]  last_rd_addr_reg;
  logic [15:0] div_count_reg;
  logic        tick_reg;
  logic [5:0]  pulse_count_reg;
  logic [4:0]  run_index_reg;

  logic        run_enable;
  logic        hsec_step;
  logic [5:0]  pulse_target;
  logic        hsec_wrap;
  logic        sec_wrap;
  logic        min_wrap;
  logic        hour_wrap;
  logic [7:0]  hundredths_next;
  logic [7:0]  seconds_next;
  logic [7:0]  minutes_next;
  logic [7:0]  hours_next;
  logic [4:0]  hours12_value;
  logic [7:0]  seconds_inc;
  logic [7:0]  hours12_inc;
  logic [7:0]  hours24_inc;
  logic        capture;
  logic [7:0]  reg_rdata_next;

  assign run_enable = seconds_count_and_run_reg[RUN_BIT];

  // ----------------------------------------
  // 4096 Hz tick divider
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      div_count_reg <= 16'h0000;
      tick_reg      <= 1'b0;
    end
    else if (!run_enable)
    begin
      div_count_reg <= 16'h0000;
      tick_reg      <= 1'b0;
    end
    else if (div_count_reg == 16'(TICK_DIV_P - 1))
    begin
      div_count_reg <= 16'h0000;
      tick_reg      <= 1'b1;
    end
    else
    begin
      div_count_reg <= div_count_reg + 16'h0001;
      tick_reg      <= 1'b0;
    end
  end

  // ----------------------------------------
  // Hundredths pacing: 24 steps of 41 ticks, one of 40
  // ----------------------------------------
  assign pulse_target = (run_index_reg == HSEC_LONG_RUNS) ? HSEC_SHORT : HSEC_LONG;
  assign hsec_step    = tick_reg && run_enable && (pulse_count_reg == pulse_target - 6'h01);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pulse_count_reg <= 6'h00;
      run_index_reg   <= 5'h00;
    end
    else if (hsec_step)
    begin
      pulse_count_reg <= 6'h00;
      run_index_reg   <= (run_index_reg == HSEC_LONG_RUNS) ? 5'h00 : run_index_reg + 5'h01;
    end
    else if (tick_reg && run_enable)
    begin
      pulse_count_reg <= pulse_count_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // Counting chain
  // ----------------------------------------
  // Hundredths BCD step
  assign hsec_wrap = hundredths_count_reg == HUNDREDTHS_LAST;
  assign sec_wrap  = seconds_count_and_run_reg[6:0] == SIXTY_LAST;
  assign min_wrap  = minutes_count_reg[6:0] == SIXTY_LAST;
  assign hours12_value = hours_count_and_format_reg[4:0];
  assign seconds_inc   = bcd_inc({1'b0, seconds_count_and_run_reg[6:0]});
  assign hours12_inc   = bcd_inc({3'b000, hours12_value});
  assign hours24_inc   = bcd_inc({2'b00, hours_count_and_format_reg[5:0]});

  always_comb
  begin
    hundredths_next = hundredths_count_reg;
    seconds_next    = seconds_count_and_run_reg;
    minutes_next    = minutes_count_reg;
    hours_next      = hours_count_and_format_reg;
    hour_wrap       = 1'b0;
    if (hsec_step)
    begin
      hundredths_next = hsec_wrap ? RESET_VALUE : bcd_inc(hundredths_count_reg);
      if (hsec_wrap)
      begin
        seconds_next[6:0] = sec_wrap ? 7'h00 : seconds_inc[6:0];
        if (sec_wrap)
        begin
          minutes_next = min_wrap ? RESET_VALUE : (bcd_inc(minutes_count_reg) & MINUTES_MASK);
          if (min_wrap)
          begin
            if (hours_count_and_format_reg[FMT12_BIT])
            begin
              if (hours12_value == HOURS12_NOON)
              begin
                hours_next[4:0] = HOURS12_FIRST;
              end
              else if (hours12_value == HOURS12_ELEVEN)
              begin
                hours_next[4:0]    = HOURS12_NOON;
                hours_next[PM_BIT] = ~hours_count_and_format_reg[PM_BIT];
                hour_wrap          = hours_count_and_format_reg[PM_BIT];
              end
              else
              begin
                hours_next[4:0] = hours12_inc[4:0];
              end
            end
            else if (hours_count_and_format_reg[5:0] == HOURS24_LAST)
            begin
              hours_next[5:0] = 6'h00;
              hour_wrap       = 1'b1;
            end
            else
            begin
              hours_next[5:0] = hours24_inc[5:0];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Counter registers, host write wins per register
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      hundredths_count_reg <= RESET_VALUE;
    else if (reg_wr && reg_addr == ADDR_HUNDREDTHS)
      hundredths_count_reg <= reg_wdata;
    else
      hundredths_count_reg <= hundredths_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      seconds_count_and_run_reg <= RESET_VALUE;
    else if (reg_wr && reg_addr == ADDR_SECONDS)
      seconds_count_and_run_reg <= reg_wdata;
    else
      seconds_count_and_run_reg <= seconds_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      minutes_count_reg <= RESET_VALUE;
    else if (reg_wr && reg_addr == ADDR_MINUTES)
      minutes_count_reg <= reg_wdata & MINUTES_MASK;
    else
      minutes_count_reg <= minutes_next;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      hours_count_and_format_reg <= RESET_VALUE;
    else if (reg_wr && reg_addr == ADDR_HOURS)
      hours_count_and_format_reg <= reg_wdata;
    else
      hours_count_and_format_reg <= hours_next;
  end

  // ----------------------------------------
  // Read snapshot and data
  // ----------------------------------------
  assign live_value[0] = hundredths_count_reg;
  assign live_value[1] = seconds_count_and_run_reg;
  assign live_value[2] = minutes_count_reg;
  assign live_value[3] = hours_count_and_format_reg;

  assign capture = read_start ||
                   (reg_rd && reg_addr == ADDR_HUNDREDTHS && last_rd_addr_reg == ADDR_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TOD_REGS; gi++)
    begin : g_snap
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
          snapshot_reg[gi] <= RESET_VALUE;
        else if (capture)
          snapshot_reg[gi] <= live_value[gi];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      last_rd_addr_reg <= 5'h00;
    // A read that starts at the last address must still see the wrap
    else if (reg_rd)
      last_rd_addr_reg <= reg_addr;
    else if (read_start)
      last_rd_addr_reg <= 5'h00;
  end

  always_comb
  begin
    reg_rdata_next = READ_UNMAPPED;
    if (reg_addr <= ADDR_HOURS)
      reg_rdata_next = capture ? live_value[reg_addr[1:0]] : snapshot_reg[reg_addr[1:0]];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      reg_rdata <= READ_UNMAPPED;
    else if (reg_rd)
      reg_rdata <= reg_rdata_next;
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      osc_running    <= 1'b0;
      trim_direction <= 1'b0;
      day_carry      <= 1'b0;
    end
    else
    begin
      osc_running    <= run_enable;
      trim_direction <= hours_count_and_format_reg[TRIM_BIT];
      day_carry      <= hour_wrap;
    end
  end

endmodule

// ==== test/rtctod_checker.sv ====
// Port checker for the time-of-day registers
`timescale 1ns/1ps
module rtctod_checker
  import rtctod_pkg::*;
#(
  parameter int TICK_DIV_P = TICK_DIV
)
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       osc_running,
  input wire logic       trim_direction,
  input wire logic       day_carry
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_run_wr;
    reg_wr && reg_addr == ADDR_SECONDS;
  endsequence
  sequence s_trim_wr;
    reg_wr && reg_addr == ADDR_HOURS;
  endsequence
  AST_RUN_FOLLOWS:
    assert property (s_run_wr |=> ##1 osc_running == $past(reg_wdata[RUN_BIT], 2))
    else $error("run flag does not follow the write");
  AST_TRIM_FOLLOWS:
    assert property (s_trim_wr |=> ##1 trim_direction == $past(reg_wdata[TRIM_BIT], 2))
    else $error("trim flag does not follow the write");
  AST_UNMAPPED_ZERO:
    assert property (reg_rd && reg_addr > ADDR_HOURS |=> reg_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  AST_MIN_FIELDS:
    assert property (reg_rd && reg_addr == ADDR_MINUTES |=> !reg_rdata[7] && reg_rdata[6:4] <= 3'h5)
    else $error("minutes read out of form");
  AST_SEC_FIELDS:
    assert property (reg_rd && reg_addr == ADDR_SECONDS
      |=> reg_rdata[6:4] <= 3'h5 && reg_rdata[3:0] <= DIGIT_MAX)
    else $error("seconds read out of range");
  AST_HSEC_FIELDS:
    assert property (reg_rd && reg_addr == ADDR_HUNDREDTHS
      |=> reg_rdata[7:4] <= DIGIT_MAX && reg_rdata[3:0] <= DIGIT_MAX)
    else $error("hundredths read out of range");
  AST_CARRY_PULSE:
    assert property (day_carry |=> !day_carry)
    else $error("day carry longer than one cycle");
  AST_STOPPED_QUIET:
    assert property (!osc_running [*3] |-> !day_carry)
    else $error("carry while stopped");
endmodule

bind rtctod_top rtctod_checker #(.TICK_DIV_P(TICK_DIV_P)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .osc_running(osc_running), .trim_direction(trim_direction),
  .day_carry(day_carry));

// ==== test/rtctod_host.sv ====
// Host model issuing register byte strobes
`timescale 1ns/1ps
module rtctod_host
(
  input  wire logic       mclk,
  output logic            read_start,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    read_start = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, input logic st, output logic [7:0] q);
    @(posedge mclk);
    reg_rd <= 1'b1;
    read_start <= st;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    read_start <= 1'b0;
    reg_addr <= ~a;
    #1;
    q = reg_rdata;
  endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the time-of-day registers
`timescale 1ns/1ps
module tb;
  import rtctod_pkg::*;
  logic mclk, rst_b, read_start, reg_rd, reg_wr, osc_running, trim_direction, day_carry;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, q, d, e, hv, ex;
  logic [7:0] starts [5] = '{8'h23, 8'h71, 8'h51, 8'h72, 8'h09};
  int failures, n_tests, cycles;
  integer seed;
  bit ec, carry_seen;
  rtctod_top #(.TICK_DIV_P(4)) DUT (.mclk(mclk), .rst_b(rst_b), .read_start(read_start),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .osc_running(osc_running), .trim_direction(trim_direction),
    .day_carry(day_carry));
  rtctod_host h (.mclk(mclk), .read_start(read_start), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Integer model of one hour step
  function automatic logic [7:0] next_hour(input logic [7:0] r, output bit c);
    int v;
    bit pm;
    logic [1:0] t;
    pm = r[5] & r[6];
    v = (r[6] ? r[4] : r[5:4]) * 10 + r[3:0];
    c = 0;
    if (!r[6])
    begin
      v = (v + 1) % 24;
      c = (v == 0);
    end
    else
    begin
      if (v == 11)
      begin
        pm = !pm;
        c = !pm;
      end
      v = (v == 12) ? 1 : v + 1;
    end
    t = 2'(v / 10);
    return {r[7], r[6], r[6] ? {pm, t[0]} : t, 4'(v % 10)};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (day_carry === 1'b1)
      carry_seen = 1;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    seed = 32'h51a1;
    rst_b = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    for (int a = 0; a < 6; a++)
    begin
      h.rd(5'(a), 1'b0, q);
      check(q, RESET_VALUE);
    end
    h.wr(5'h04, 8'h5A);
    h.rd(5'h04, 1'b0, q);
    check(q, READ_UNMAPPED);
    for (int i = 0; i < 8; i++)
    begin
      d = 8'(({$random(seed)} % 6) * 16 + {$random(seed)} % 10);
      e = 8'(({$random(seed)} % 10) * 16 + {$random(seed)} % 10);
      h.wr(ADDR_SECONDS, d);
      h.wr(ADDR_MINUTES, d | 8'h80);
      h.wr(ADDR_HUNDREDTHS, e);
      h.rd(ADDR_HUNDREDTHS, 1'b1, q);
      check(q, e);
      h.rd(ADDR_SECONDS, 1'b0, q);
      check(q, d);
      h.rd(ADDR_MINUTES, 1'b0, q);
      check(q, d);
    end
    foreach (starts[k])
    begin
      hv = {1'({$random(seed)} % 2), starts[k][6:0]};
      ex = next_hour(hv, ec);
      h.wr(ADDR_SECONDS, 8'h59);
      h.wr(ADDR_HUNDREDTHS, 8'h99);
      h.wr(ADDR_MINUTES, 8'h59);
      h.wr(ADDR_HOURS, hv);
      h.rd(ADDR_HOURS, 1'b1, q);
      check(q, hv);
      check({7'h0, trim_direction}, {7'h0, hv[7]});
      carry_seen = 0;
      h.wr(ADDR_SECONDS, 8'hD9);
      for (int w = 0; w < 400 && !carry_seen; w++)
        @(posedge mclk);
      check({7'h0, osc_running}, 8'h01);
      h.rd(ADDR_HOURS, 1'b0, q);
      check(q, hv);
      h.rd(ADDR_LAST, 1'b0, q);
      check(q, READ_UNMAPPED);
      h.rd(ADDR_HUNDREDTHS, 1'b0, q);
      h.rd(ADDR_HOURS, 1'b0, q);
      check(q, ex);
      h.rd(ADDR_MINUTES, 1'b0, q);
      check(q, 8'h00);
      h.rd(ADDR_SECONDS, 1'b0, q);
      check(q, 8'h80);
      check({7'h0, carry_seen}, {7'h0, ec});
    end
    conclude();
  end
endmodule
